/* File: hw/misc_register_bank_pkg.sv */
// Purpose: Shared constants for the miscellaneous register bank.
// Assumes: Word-aligned register offsets inside a small bank window.
// Notes:   Offsets are byte addresses relative to the bank base.
package misc_register_bank_pkg;

    // Width of the offset field that is decoded inside the bank window.
    localparam int BANK_ADDR_W = 9;

    // Register byte offsets.
    localparam logic [BANK_ADDR_W-1:0] OFS_BUS_ERROR_ADDR   = 9'h004;
    localparam logic [BANK_ADDR_W-1:0] OFS_BUS_ERROR_CTRL   = 9'h014;
    localparam logic [BANK_ADDR_W-1:0] OFS_IRQ_VECTOR_MODE  = 9'h018;
    localparam logic [BANK_ADDR_W-1:0] OFS_WATCHDOG_COUNT   = 9'h028;
    localparam logic [BANK_ADDR_W-1:0] OFS_POWER_STATUS     = 9'h0F0;

    // Bus error control field layout.
    localparam int BUS_ERROR_CTRL_W     = 2;
    localparam int FLD_EXCEPTION_OFF    = 0;
    localparam int FLD_ERROR_CTRL_SPARE = 1;

    // Interrupt vector mode and power status field positions.
    localparam int FLD_DIRECT_VECTOR    = 0;
    localparam int FLD_SLEEP_ACK        = 0;

    // Reset values.
    localparam logic [31:0] RST_BUS_ERROR_ADDR = 32'h0000_0000;
    localparam logic [BUS_ERROR_CTRL_W-1:0] RST_BUS_ERROR_CTRL = 2'h0;
    localparam logic RST_DIRECT_VECTOR_ENABLE = 1'b1;
    localparam logic [31:0] RST_WATCHDOG_COUNT = 32'h0000_0000;

    // AHB-Lite encodings used by the slave.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;
    localparam logic [31:0] READ_ZERO    = 32'h0000_0000;

    // Data-phase tracking of the bus slave.
    typedef enum logic [1:0] {
        PHASE_IDLE  = 2'b00,
        PHASE_WRITE = 2'b01,
        PHASE_READ  = 2'b10
    } bus_phase_type;

endpackage : misc_register_bank_pkg

/* File: hw/irq_vector_router.sv */
// Purpose: Steers peripheral interrupt events to direct or shared vectors.
// Assumes: Events are synchronous levels on the core clock.
// Notes:   Outputs are registered, so routing adds one cycle of latency.
`timescale 1ns/1ps
module irq_vector_router #(
    parameter int NUM_EVENTS = 8
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_ce,
    input  wire logic                  i_rst,
    input  wire logic                  i_direct_vector_enable,
    input  wire logic [NUM_EVENTS-1:0] i_events,
    output logic      [NUM_EVENTS-1:0] o_direct_irq,
    output logic                       o_aggregated_irq
);

    // With direct vectors on, each event owns its line; otherwise all
    // events share the single aggregated line and the direct ones rest.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_direct_irq     <= '0;
            o_aggregated_irq <= 1'b0;
        end
        else if (i_ce)
        begin
            o_direct_irq     <= i_events & {NUM_EVENTS{i_direct_vector_enable}};
            o_aggregated_irq <= (|i_events) & ~i_direct_vector_enable;
        end
    end

endmodule : irq_vector_router

/* File: hw/misc_register_bank.sv */
// Purpose: Miscellaneous control and status registers on AHB-Lite.
// Assumes: All inputs are synchronous to I_CORE_CLK; resets synchronous.
// Notes:   Reads take one wait state so a write just before is visible.
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
//
// Contract
// - No private clock; every register access runs on the core clock.
// - System reset restores all state except the watchdog event count.
// - Watchdog count resets only by power-on reset and the reset that excludes watchdog events.
// - Core-well power-on reset acts only at first power-up of the well.
// - The bank raises no interrupt request of its own.
// - Register reads and writes keep working while the bank sleeps.
// - Registers decode at base plus offsets 04h, 14h, 18h, 28h and F0h.
// - A master bus error loads its address only if capture holds zero or a write clears it in the same cycle.
// - Any write to the capture register clears it; a new capture wins.
// - Capture register reads zero after system reset.
// - Control bit 0 set suppresses memory exceptions; resets to zero.
// - Control bits 7:2 are reserved and hold no state.
// - Vector mode bit 0 selects direct vectors, resets to one.
// - Direct mode routes each event to its own processor vector.
module misc_register_bank
    import misc_register_bank_pkg::*;
#(
    parameter int NUM_EVENTS   = 8,
    parameter int WATCHDOG_W   = 32
) (
    input  wire logic                  I_CORE_CLK,
    input  wire logic                  I_RSTN,
    input  wire logic                  I_CE,
    input  wire logic                  I_SYSTEM_RESET,
    input  wire logic                  I_SYSTEM_RESET_EXCEPT_WATCHDOG,
    input  wire logic                  I_SLEEP_REQ,
    input  wire logic                  I_HSEL,
    input  wire logic [31:0]           I_HADDR,
    input  wire logic [1:0]            I_HTRANS,
    input  wire logic                  I_HWRITE,
    input  wire logic [2:0]            I_HSIZE,
    input  wire logic [31:0]           I_HWDATA,
    input  wire logic                  I_HREADY,
    output logic      [31:0]           O_HRDATA,
    output logic                       O_HREADYOUT,
    output logic                       O_HRESP,
    input  wire logic                  I_MASTER_ERROR,
    input  wire logic [31:0]           I_MASTER_ERROR_ADDR,
    input  wire logic                  I_WATCHDOG_EVENT,
    input  wire logic [NUM_EVENTS-1:0] I_IRQ_EVENTS,
    output logic                       O_MEMORY_EXCEPTION,
    output logic                       O_SLEEP_ACK,
    output logic      [NUM_EVENTS-1:0] O_DIRECT_IRQ,
    output logic                       O_AGGREGATED_IRQ
);
    import misc_register_bank_pkg::*;

    // Reset terms. I_RSTN is the core-well power-on reset.
    logic                          por;
    logic                          logic_reset;
    logic                          watchdog_reset;

    // Bus slave state.
    bus_phase_type                 phase;
    logic [BANK_ADDR_W-1:0]        phase_addr;
    logic                          addr_taken;
    logic [31:0]                   next_rdata;

    // Register state.
    logic [31:0]                   bus_error_addr;
    logic [BUS_ERROR_CTRL_W-1:0]   bus_error_ctrl;
    logic                          direct_vector_enable;
    logic [WATCHDOG_W-1:0]         watchdog_count;

    // Decoded write strobes, valid in the data phase of a write.
    logic                          wr_error_addr;
    logic                          wr_error_ctrl;
    logic                          wr_vector_mode;
    logic                          wr_watchdog;
    logic                          capture_error;

    // The power-on reset is only ever asserted when the core well first
    // comes up, so it is taken straight from the pin and covers all state.
    assign por = ~I_RSTN;

    // System reset clears everything except the watchdog event count.
    assign logic_reset = por | I_SYSTEM_RESET;

    // The watchdog count survives a watchdog-caused system reset; only power-on
    // reset and the variant that is never asserted by a watchdog event clear it.
    assign watchdog_reset = por | I_SYSTEM_RESET_EXCEPT_WATCHDOG;

    // An address phase is taken when the bus is ready and this slave is
    // selected with a non-sequential transfer. Only single words are used,
    // so the size is accepted without checking.
    assign addr_taken = I_CE
                      & I_HREADY
                      & I_HSEL
                      & (I_HTRANS == HTRANS_NONSEQ);

    // Reads stall one cycle so the data flop is loaded after any write that
    // completed at the same edge the read address was taken. Writes are
    // zero wait. A low clock enable holds the bus off while state is frozen.
    assign O_HREADYOUT = I_CE & (phase != PHASE_READ);

    // Every transfer completes OKAY, mapped or not. There is no error path,
    // so firmware probing a hole in the map cannot fault on this bank, at
    // the price of never being told that the offset was wrong.
    assign O_HRESP = HRESP_OKAY;

    // Track the data phase of each transfer. All bus handling is clocked by
    // the core clock; the bank has no clock of its own.
    always_ff @(posedge I_CORE_CLK)
    begin
        if (logic_reset)
        begin
            phase      <= PHASE_IDLE;
            phase_addr <= '0;
        end
        else if (I_CE)
        begin
            case (phase)
                PHASE_READ:
                begin
                    phase <= PHASE_IDLE;
                end
                default:
                begin
                    if (addr_taken)
                    begin
                        phase_addr <= I_HADDR[BANK_ADDR_W-1:0];
                        if (I_HWRITE)
                        begin
                            phase <= PHASE_WRITE;
                        end
                        else
                        begin
                            phase <= PHASE_READ;
                        end
                    end
                    else
                    begin
                        phase <= PHASE_IDLE;
                    end
                end
            endcase
        end
    end

    // Write strobes by offset; unmapped offsets produce no strobe, so a
    // write there is dropped without an error.
    always_comb
    begin
        wr_error_addr  = 1'b0;
        wr_error_ctrl  = 1'b0;
        wr_vector_mode = 1'b0;
        wr_watchdog    = 1'b0;
        if (phase == PHASE_WRITE && I_CE)
        begin
            if (phase_addr == OFS_BUS_ERROR_ADDR)
            begin
                wr_error_addr = 1'b1;
            end
            else if (phase_addr == OFS_BUS_ERROR_CTRL)
            begin
                wr_error_ctrl = 1'b1;
            end
            else if (phase_addr == OFS_IRQ_VECTOR_MODE)
            begin
                wr_vector_mode = 1'b1;
            end
            else if (phase_addr == OFS_WATCHDOG_COUNT)
            begin
                wr_watchdog = 1'b1;
            end
        end
    end

    // A new error is captured when the register is empty, or when a clearing
    // write lands in the same cycle: the capture outranks the clear, so the
    // first fault after software acknowledges is never lost.
    assign capture_error = I_CE
                         & I_MASTER_ERROR
                         & ((bus_error_addr == RST_BUS_ERROR_ADDR)
                            | wr_error_addr);

    // Bus error capture register. Limitation: a fault at address zero is
    // indistinguishable from an empty register and does not lock it.
    always_ff @(posedge I_CORE_CLK)
    begin
        if (logic_reset)
        begin
            bus_error_addr <= RST_BUS_ERROR_ADDR;
        end
        else if (capture_error)
        begin
            bus_error_addr <= I_MASTER_ERROR_ADDR;
        end
        else if (wr_error_addr)
        begin
            bus_error_addr <= RST_BUS_ERROR_ADDR;
        end
    end

    // Bus error control. Only the two low bits are flops; the upper bits of
    // the byte are reserved and are never stored.
    always_ff @(posedge I_CORE_CLK)
    begin
        if (logic_reset)
        begin
            bus_error_ctrl <= RST_BUS_ERROR_CTRL;
        end
        else if (wr_error_ctrl)
        begin
            bus_error_ctrl <= I_HWDATA[BUS_ERROR_CTRL_W-1:0];
        end
    end

    // Interrupt vector mode; direct vectors are on after reset.
    always_ff @(posedge I_CORE_CLK)
    begin
        if (logic_reset)
        begin
            direct_vector_enable <= RST_DIRECT_VECTOR_ENABLE;
        end
        else if (wr_vector_mode)
        begin
            direct_vector_enable <= I_HWDATA[FLD_DIRECT_VECTOR];
        end
    end

    // Watchdog event count. Software may preset it; an event arriving with
    // the write still counts on top of the written value.
    always_ff @(posedge I_CORE_CLK)
    begin
        if (watchdog_reset)
        begin
            watchdog_count <= RST_WATCHDOG_COUNT[WATCHDOG_W-1:0];
        end
        else if (I_CE)
        begin
            if (wr_watchdog)
            begin
                watchdog_count <= I_HWDATA[WATCHDOG_W-1:0]
                                + WATCHDOG_W'(I_WATCHDOG_EVENT);
            end
            else if (I_WATCHDOG_EVENT)
            begin
                watchdog_count <= watchdog_count + WATCHDOG_W'(1'b1);
            end
        end
    end

    // Forward master faults as memory exceptions unless suppressed. This
    // reports the processor's own fault, not an interrupt of the bank.
    always_ff @(posedge I_CORE_CLK)
    begin
        if (logic_reset)
        begin
            O_MEMORY_EXCEPTION <= 1'b0;
        end
        else if (I_CE)
        begin
            O_MEMORY_EXCEPTION <= I_MASTER_ERROR
                                & ~bus_error_ctrl[FLD_EXCEPTION_OFF];
        end
    end

    // Sleep handshake. The acknowledge is only a status: the bus slave
    // above has no term on it, so accesses go on while asleep.
    always_ff @(posedge I_CORE_CLK)
    begin
        if (logic_reset)
        begin
            O_SLEEP_ACK <= 1'b0;
        end
        else if (I_CE)
        begin
            O_SLEEP_ACK <= I_SLEEP_REQ;
        end
    end

    // Read multiplexer. Reserved bits and unmapped offsets read as zero.
    always_comb
    begin
        next_rdata = READ_ZERO;
        if (phase_addr == OFS_BUS_ERROR_ADDR)
        begin
            next_rdata = bus_error_addr;
        end
        else if (phase_addr == OFS_BUS_ERROR_CTRL)
        begin
            next_rdata[BUS_ERROR_CTRL_W-1:0] = bus_error_ctrl;
        end
        else if (phase_addr == OFS_IRQ_VECTOR_MODE)
        begin
            next_rdata[FLD_DIRECT_VECTOR] = direct_vector_enable;
        end
        else if (phase_addr == OFS_WATCHDOG_COUNT)
        begin
            next_rdata[WATCHDOG_W-1:0] = watchdog_count;
        end
        else if (phase_addr == OFS_POWER_STATUS)
        begin
            next_rdata[FLD_SLEEP_ACK] = O_SLEEP_ACK;
        end
        else
        begin
            next_rdata = READ_ZERO;
        end
    end

    // Read data flop, loaded in the wait cycle of a read. It holds its
    // value otherwise, so it stands through the completing cycle. The wait
    // costs one cycle per read but keeps the multiplexer off the bus path.
    // Only reset otherwise loads it, so stale data never changes under the master.
    always_ff @(posedge I_CORE_CLK)
    begin
        if (logic_reset)
        begin
            O_HRDATA <= READ_ZERO;
        end
        else if (I_CE && phase == PHASE_READ)
        begin
            O_HRDATA <= next_rdata;
        end
    end

    // Interrupt routing for the subsystem's peripherals. The bank itself
    // feeds no event into it and owns no request line. Its outputs lag the
    // events by one cycle, which a mode change follows as well.
    irq_vector_router #(
        .NUM_EVENTS             (NUM_EVENTS)
    ) u_router (
        .i_clk                  (I_CORE_CLK),
        .i_ce                   (I_CE),
        .i_rst                  (logic_reset),
        .i_direct_vector_enable (direct_vector_enable),
        .i_events               (I_IRQ_EVENTS),
        .o_direct_irq           (O_DIRECT_IRQ),
        .o_aggregated_irq       (O_AGGREGATED_IRQ)
    );

endmodule : misc_register_bank

/* File: bench/misc_bank_properties.sv */
// Purpose: Port-level assertions for the miscellaneous register bank.
// Assumes: Only top-level ports are visible; one clock domain.
// Notes:   Attached by the bind statement at the foot of this file.
`timescale 1ns/1ps
module misc_bank_checker
    import misc_register_bank_pkg::*;
#(
    parameter int NUM_EVENTS = 8
) (
    input wire logic                  I_CORE_CLK,
    input wire logic                  I_RSTN,
    input wire logic                  I_CE,
    input wire logic                  I_SYSTEM_RESET,
    input wire logic                  I_SLEEP_REQ,
    input wire logic                  I_HSEL,
    input wire logic [1:0]            I_HTRANS,
    input wire logic                  I_HWRITE,
    input wire logic                  I_HREADY,
    input wire logic [31:0]           O_HRDATA,
    input wire logic                  O_HREADYOUT,
    input wire logic                  O_HRESP,
    input wire logic                  I_MASTER_ERROR,
    input wire logic [NUM_EVENTS-1:0] I_IRQ_EVENTS,
    input wire logic                  O_MEMORY_EXCEPTION,
    input wire logic                  O_SLEEP_ACK,
    input wire logic [NUM_EVENTS-1:0] O_DIRECT_IRQ,
    input wire logic                  O_AGGREGATED_IRQ
);
    default clocking cb @(posedge I_CORE_CLK);
    endclocking

    // Qualified bus requests; live is low while either reset acts.
    logic take;
    logic live;
    assign take = I_CE && I_HREADY && I_HSEL && I_HTRANS == HTRANS_NONSEQ;
    assign live = I_RSTN && !I_SYSTEM_RESET;

    a_hresp_okay: assert property (O_HRESP == HRESP_OKAY)
        else $error("bus response not OKAY");
    a_ce_stall: assert property (!I_CE |-> !O_HREADYOUT)
        else $error("ready while clock enable low");
    a_read_wait: assert property (disable iff (!live)
        take && !I_HWRITE |=> !O_HREADYOUT ##1
        (O_HREADYOUT || !I_CE || !$past(I_CE)))
        else $error("read wait state wrong");
    a_write_nowait: assert property (disable iff (!live)
        take && I_HWRITE |=> O_HREADYOUT || !I_CE)
        else $error("write stalled");
    a_reset_quiet: assert property (!live |=> O_HRDATA == READ_ZERO
        && !O_MEMORY_EXCEPTION && O_DIRECT_IRQ == '0 && !O_AGGREGATED_IRQ
        && !O_SLEEP_ACK)
        else $error("outputs not cleared by reset");
    a_exc_cause: assert property (disable iff (!live)
        O_MEMORY_EXCEPTION && $past(I_CE) |-> $past(I_MASTER_ERROR))
        else $error("exception without bus error");
    a_sleep_follow: assert property (disable iff (!live)
        $past(live && I_CE) |-> O_SLEEP_ACK == $past(I_SLEEP_REQ))
        else $error("sleep acknowledge wrong");
    a_route_one: assert property (disable iff (!live)
        $past(live && I_CE && |I_IRQ_EVENTS) |->
        (O_DIRECT_IRQ == $past(I_IRQ_EVENTS)) != O_AGGREGATED_IRQ)
        else $error("event not routed to exactly one path");
    a_route_shared: assert property (disable iff (!live)
        O_AGGREGATED_IRQ && $past(I_CE) |->
        O_DIRECT_IRQ == '0 && $past(|I_IRQ_EVENTS))
        else $error("shared vector wrong");

    c_read: cover property (take && !I_HWRITE);
    c_shared: cover property (O_AGGREGATED_IRQ);
    c_exc: cover property (O_MEMORY_EXCEPTION);
endmodule : misc_bank_checker

bind misc_register_bank misc_bank_checker #(.NUM_EVENTS(NUM_EVENTS)) i_chk (
    .I_CORE_CLK(I_CORE_CLK), .I_RSTN(I_RSTN), .I_CE(I_CE),
    .I_SYSTEM_RESET(I_SYSTEM_RESET), .I_SLEEP_REQ(I_SLEEP_REQ),
    .I_HSEL(I_HSEL), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE),
    .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT),
    .O_HRESP(O_HRESP), .I_MASTER_ERROR(I_MASTER_ERROR),
    .I_IRQ_EVENTS(I_IRQ_EVENTS), .O_MEMORY_EXCEPTION(O_MEMORY_EXCEPTION),
    .O_SLEEP_ACK(O_SLEEP_ACK), .O_DIRECT_IRQ(O_DIRECT_IRQ),
    .O_AGGREGATED_IRQ(O_AGGREGATED_IRQ));

/* File: bench/processor_fault_source.sv */
// Purpose: Processor-side model that reports master bus errors.
// Assumes: Fire is driven just after a rising edge.
// Notes:   Address is scrambled outside the error pulse.
`timescale 1ns/1ps
module processor_fault_source (
    input  wire logic        i_clk,
    input  wire logic        i_fire,
    input  wire logic [31:0] i_addr,
    output logic             o_error,
    output logic [31:0]      o_error_addr
);
    // One-cycle error with its address; outside it the address shows the
    // inverse, so that a stale value can never pass for a captured one.
    always @(posedge i_clk)
    begin
        o_error <= i_fire;
        o_error_addr <= i_fire ? i_addr : ~i_addr;
    end
endmodule : processor_fault_source

/* File: bench/misc_register_bank_bench.sv */
// Purpose: Self-checking bench for the miscellaneous register bank.
// Assumes: Single 25 MHz clock; bus master waits on ready.
// Notes:   Random data from a fixed seed mixed with corner cases.
`timescale 1ns/1ps
module misc_register_bank_bench;
    import misc_register_bank_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, ce = 1'b1, srst = 1'b1;
    logic        wrst = 1'b1, sleep = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        wd_ev = 1'b0, fire = 1'b0, hready, hreadyout, hresp;
    logic        merr, mexc, sack, airq;
    logic [1:0]  htrans = 2'h0;
    logic [7:0]  ev = 8'h00, dirq, e;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, faddr = 32'h0;
    logic [31:0] hrdata, merr_addr, d, w;
    int          fails = 0, n_checks = 0, n_exc = 0, rnd;

    always #20 clk = ~clk;
    assign hready = hreadyout;
    always @(posedge clk) if (mexc === 1'b1) n_exc++;

    misc_register_bank i_dut (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_CE(ce),
        .I_SYSTEM_RESET(srst), .I_SYSTEM_RESET_EXCEPT_WATCHDOG(wrst),
        .I_SLEEP_REQ(sleep), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
        .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
        .O_HREADYOUT(hreadyout), .O_HRESP(hresp), .I_MASTER_ERROR(merr),
        .I_MASTER_ERROR_ADDR(merr_addr), .I_WATCHDOG_EVENT(wd_ev),
        .I_IRQ_EVENTS(ev), .O_MEMORY_EXCEPTION(mexc), .O_SLEEP_ACK(sack),
        .O_DIRECT_IRQ(dirq), .O_AGGREGATED_IRQ(airq));
    processor_fault_source i_cpu (.i_clk(clk), .i_fire(fire),
        .i_addr(faddr), .o_error(merr), .o_error_addr(merr_addr));

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    // Samples ready at the falling edge, which equals its value at the
    // next rising edge, and returns at that falling edge. There is no
    // limit here: a hung slave is caught by the watchdog process.
    task automatic wait_ready();
        do
        begin
            @(negedge clk);
        end
        while (hreadyout !== 1'b1);
    endtask : wait_ready

    task automatic bus(input logic wr, input logic [8:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {23'h0, a};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        wait_ready();
        @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        @(posedge clk);
    endtask : bus

    task automatic wr(input logic [8:0] a, input logic [31:0] v);
        logic [31:0] x;
        bus(1'b1, a, v, x);
    endtask : wr

    task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        check($sformatf("read %h", a), x, exp);
    endtask : rd_chk

    task automatic err(input logic [31:0] a);
        fire <= 1'b1;
        faddr <= a;
        @(posedge clk);
        fire <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : err

    // Kind 0 system reset, 1 watchdog-excluding reset, 2 power-on reset.
    task automatic hold(input int k);
        if (k == 0) srst <= 1'b1;
        else if (k == 1) wrst <= 1'b1;
        else rstn <= 1'b0;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        wrst <= 1'b0;
        rstn <= 1'b1;
        @(posedge clk);
    endtask : hold

    function automatic logic [8:0] route(input int m, input logic [7:0] x);
        return (m == 1) ? {1'b0, x} : {|x, 8'h00};
    endfunction : route

    initial
    begin
        #(40 * 20000);
        fails++;
        wrap_up();
    end

    initial
    begin
        rnd = $urandom(32'h9162A6BB);
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        srst <= 1'b0;
        wrst <= 1'b0;
        @(posedge clk);
        rd_chk(OFS_BUS_ERROR_ADDR, 32'h0);
        rd_chk(OFS_BUS_ERROR_CTRL, 32'h0);
        rd_chk(OFS_IRQ_VECTOR_MODE, 32'h1);
        rd_chk(9'h000, 32'h0);
        wr(9'h01C, 32'hFFFF_FFFF);
        rd_chk(9'h01C, 32'h0);
        wr(OFS_BUS_ERROR_CTRL, 32'hFFFF_FFFF);
        rd_chk(OFS_BUS_ERROR_CTRL, 32'h3);
        wr(OFS_IRQ_VECTOR_MODE, 32'hFFFF_FFFE);
        rd_chk(OFS_IRQ_VECTOR_MODE, 32'h0);
        wr(OFS_BUS_ERROR_CTRL, 32'h0);
        // Routing in shared mode, then direct mode.
        for (int m = 0; m < 2; m++)
        begin
            wr(OFS_IRQ_VECTOR_MODE, 32'(m));
            repeat (4)
            begin
                e = 8'($urandom);
                ev <= e;
                @(posedge clk);
                @(negedge clk);
                check("routing", 32'({airq, dirq}), 32'(route(m, e)));
                @(posedge clk);
            end
        end
        ev <= 8'h00;
        // First fault is kept; a later one is not.
        d = $urandom | 32'h1;
        err(d);
        rd_chk(OFS_BUS_ERROR_ADDR, d);
        err(~d);
        rd_chk(OFS_BUS_ERROR_ADDR, d);
        check("exceptions", 32'(n_exc), 32'h2);
        wr(OFS_BUS_ERROR_CTRL, 32'h1);
        err(32'($urandom));
        check("exceptions", 32'(n_exc), 32'h2);
        wr(OFS_BUS_ERROR_ADDR, 32'($urandom));
        rd_chk(OFS_BUS_ERROR_ADDR, 32'h0);
        // A fault landing with a clearing write wins over the clear.
        d = $urandom | 32'h1;
        fork
            wr(OFS_BUS_ERROR_ADDR, ~d);
            err(d);
        join
        rd_chk(OFS_BUS_ERROR_ADDR, d);
        // Watchdog count across the three resets.
        w = $urandom;
        wr(OFS_WATCHDOG_COUNT, w);
        repeat (3)
        begin
            wd_ev <= 1'b1;
            @(posedge clk);
            wd_ev <= 1'b0;
            @(posedge clk);
        end
        wr(OFS_IRQ_VECTOR_MODE, 32'h0);
        hold(0);
        rd_chk(OFS_WATCHDOG_COUNT, w + 32'h3);
        rd_chk(OFS_IRQ_VECTOR_MODE, 32'h1);
        rd_chk(OFS_BUS_ERROR_CTRL, 32'h0);
        rd_chk(OFS_BUS_ERROR_ADDR, 32'h0);
        hold(1);
        rd_chk(OFS_WATCHDOG_COUNT, 32'h0);
        wr(OFS_WATCHDOG_COUNT, w);
        wr(OFS_IRQ_VECTOR_MODE, 32'h0);
        hold(2);
        rd_chk(OFS_WATCHDOG_COUNT, 32'h0);
        rd_chk(OFS_IRQ_VECTOR_MODE, 32'h1);
        // Register access while asleep, with a stalled start.
        sleep <= 1'b1;
        wr(OFS_BUS_ERROR_CTRL, 32'h1);
        rd_chk(OFS_POWER_STATUS, 32'h1);
        check("sleep ack", 32'(sack), 32'h1);
        ce <= 1'b0;
        fork
            wr(OFS_BUS_ERROR_CTRL, 32'h2);
            begin
                repeat (3) @(posedge clk);
                ce <= 1'b1;
            end
        join
        rd_chk(OFS_BUS_ERROR_CTRL, 32'h2);
        sleep <= 1'b0;
        repeat (2) @(posedge clk);
        wrap_up();
    end
endmodule : misc_register_bank_bench
